// ---- bench/bus_ctrl_model.sv ----
// Behavioural two-wire bus controller that reaches the routing register bank
`timescale 1ns/1ps
module bus_ctrl_model (
  // Clock
  input wire logic sys_clk,
  // Bus lines, released level is high through the pullup
  input wire logic sda_line,
  output logic scl_drv,
  output logic sda_drv
);
  int half = 20;

  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Clock phases are timed only by the controller, no stretching is awaited
  task automatic put_bit(input logic b);
    sda_drv = b;
    tick(half);
    scl_drv = 1'b1;
    tick(half);
    scl_drv = 1'b0;
  endtask

  task automatic get_bit(output logic b);
    sda_drv = 1'b1;
    tick(half);
    scl_drv = 1'b1;
    tick(half / 2);
    b = sda_line;
    tick(half - half / 2);
    scl_drv = 1'b0;
  endtask

  task automatic start_cond();
    sda_drv = 1'b1;
    tick(half);
    scl_drv = 1'b1;
    tick(half);
    sda_drv = 1'b0;
    tick(half);
    scl_drv = 1'b0;
    tick(half);
  endtask

  task automatic stop_cond();
    sda_drv = 1'b0;
    tick(half);
    scl_drv = 1'b1;
    tick(half);
    sda_drv = 1'b1;
    tick(half);
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(b);
    ack = !b;
  endtask

  task automatic recv_byte(input logic ack_it, output logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      get_bit(b);
      d[i] = b;
    end
    put_bit(!ack_it);
  endtask

  task automatic probe(input logic [6:0] addr, output logic ok);
    start_cond();
    send_byte({addr, 1'b0}, ok);
    stop_cond();
  endtask

  task automatic write_reg(input logic [6:0] addr, input logic [7:0] ptr,
                           input logic [7:0] data, output logic ok);
    logic a0;
    logic a1;
    logic a2;
    a1 = 1'b0;
    a2 = 1'b0;
    start_cond();
    send_byte({addr, 1'b0}, a0);
    if (a0) begin
      send_byte(ptr, a1);
      send_byte(data, a2);
    end
    stop_cond();
    ok = a0 & a1 & a2;
  endtask

  task automatic read_reg(input logic [6:0] addr, input logic [7:0] ptr,
                          output logic [7:0] data, output logic ok);
    logic a0;
    logic a1;
    logic a2;
    start_cond();
    send_byte({addr, 1'b0}, a0);
    send_byte(ptr, a1);
    start_cond();
    send_byte({addr, 1'b1}, a2);
    recv_byte(1'b0, data);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask
endmodule

// ---- bench/excitation_current_routing_config_test.sv ----
// Self-checking bench for the excitation routing register bank
`timescale 1ns/1ps
module excitation_current_routing_config_test;
  localparam logic [2:0] BASE = 3'h4;
  localparam int LIMIT = 90000;
  logic sys_clk;
  logic reset_n;
  logic [1:0] addr_strap_lo;
  logic [1:0] addr_strap_hi;
  logic result_pending;
  logic scl_drv;
  logic sda_drv;
  logic sda_line;
  logic sda_out;
  logic sda_oe_n;
  logic rdy_out;
  logic rdy_oe_n;
  logic rdy_line;
  logic [2:0] mag;
  logic [5:0] src1;
  logic [5:0] src2;
  int n_mismatch = 0;
  int n_checks = 0;
  int cycles = 0;

  // Open-drain lines with pullups
  assign sda_line = sda_drv & (sda_oe_n ? 1'b1 : sda_out);
  assign rdy_line = rdy_oe_n ? 1'b1 : rdy_out;

  excitation_current_routing_config #(.ADDR_BASE(BASE)) dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .scl_in(scl_drv), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_strap_lo(addr_strap_lo),
    .addr_strap_hi(addr_strap_hi), .result_pending(result_pending),
    .conversion_ready_n_out(rdy_out), .conversion_ready_oe_n(rdy_oe_n),
    .excitation_magnitude_sel(mag), .first_excitation_source(src1),
    .second_excitation_source(src2)
  );

  bus_ctrl_model ctrl (.sys_clk(sys_clk), .sda_line(sda_line), .scl_drv(scl_drv),
    .sda_drv(sda_drv));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_mismatch++;
      $display("unexpected at %0t: run did not finish", $time);
      tally_and_finish();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [5:0] conn(input logic [2:0] c);
    conn = (c == 3'h0 || c == 3'h7) ? 6'h00 : 6'h01 << (c - 3'h1);
  endfunction

  function automatic logic [6:0] addr_now();
    addr_now = {BASE, addr_strap_hi, addr_strap_lo};
  endfunction

  task automatic do_reset(input logic [3:0] straps);
    @(posedge sys_clk);
    #1;
    reset_n = 1'b0;
    {addr_strap_hi, addr_strap_lo} = straps;
    repeat (6) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    logic ok;
    ctrl.write_reg(addr_now(), ptr, d, ok);
    check({7'h00, ok}, 8'h01, "write ack");
  endtask

  task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp);
    logic ok;
    logic [7:0] d;
    ctrl.read_reg(addr_now(), ptr, d, ok);
    check({7'h00, ok}, 8'h01, "read ack");
    check(d, exp, "read data");
  endtask

  initial begin
    logic ok;
    logic [7:0] d;
    int speeds[3];
    speeds = '{200, 50, 20};
    reset_n = 1'b0;
    result_pending = 1'b0;
    {addr_strap_hi, addr_strap_lo} = 4'h9;
    do_reset(4'h9);
    check({2'h0, src1}, 8'h00, "first off after reset");
    check({2'h0, src2}, 8'h00, "second off after reset");
    rd_chk(routing_pkg::REG_ROUTING_IDX, 8'h00);
    // Standard, fast and fast-plus clock rates
    for (int s = 0; s < 3; s++) begin
      ctrl.half = speeds[s];
      wr(routing_pkg::REG_MAGNITUDE_IDX, 8'(s + 1));
      check({5'h00, mag}, 8'(s + 1), "magnitude");
      rd_chk(routing_pkg::REG_MAGNITUDE_IDX, 8'(s + 1));
    end
    // Every legal code in both fields, low bits always written as zero
    for (int c = 0; c < 7; c++) begin
      d = {c[2:0], 3'(6 - c), 2'b00};
      wr(routing_pkg::REG_ROUTING_IDX, d);
      check({2'h0, src1}, {2'h0, conn(c[2:0])}, "first route");
      check({2'h0, src2}, {2'h0, conn(3'(6 - c))}, "second route");
      rd_chk(routing_pkg::REG_ROUTING_IDX, d);
    end
    wr(routing_pkg::REG_MAGNITUDE_IDX, 8'h00);
    check({2'h0, src1}, 8'h00, "off at zero magnitude");
    rd_chk(routing_pkg::REG_ROUTING_IDX, 8'hc0);
    rd_chk(8'h05, 8'h00);
    ctrl.write_reg(addr_now() ^ 7'h01, routing_pkg::REG_ROUTING_IDX, 8'h24, ok);
    check({7'h00, ok}, 8'h00, "foreign address acked");
    rd_chk(routing_pkg::REG_ROUTING_IDX, 8'hc0);
    // Two-byte read: an acked byte makes the register go out again
    ctrl.start_cond();
    ctrl.send_byte({addr_now(), 1'b0}, ok);
    ctrl.send_byte(routing_pkg::REG_ROUTING_IDX, ok);
    ctrl.start_cond();
    ctrl.send_byte({addr_now(), 1'b1}, ok);
    check({7'h00, ok}, 8'h01, "read address ack");
    ctrl.recv_byte(1'b1, d);
    check(d, 8'hc0, "first of two bytes");
    ctrl.recv_byte(1'b0, d);
    check(d, 8'hc0, "second of two bytes");
    ctrl.stop_cond();
    for (int s = 0; s < 16; s++) begin
      do_reset(s[3:0]);
      ctrl.probe(addr_now(), ok);
      check({7'h00, ok}, 8'h01, "strap address ack");
    end
    rd_chk(routing_pkg::REG_ROUTING_IDX, 8'h00);
    result_pending = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    check({7'h00, rdy_line}, 8'h00, "ready pulled low");
    check({7'h00, rdy_out}, 8'h00, "ready drive value");
    result_pending = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    check({7'h00, rdy_line}, 8'h01, "ready released");
    tally_and_finish();
  end
endmodule

// ---- core/bus_line_sampler.sv ----
// Edge and start/stop detection on the serial bus lines
`timescale 1ns/1ps
module bus_line_sampler (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Bus lines
  input wire logic scl_in,
  input wire logic sda_in,
  // Events
  line_events_if.src ev
);
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic scl_prev_next;
  logic sda_prev_next;

  always_comb begin
    scl_prev_next = scl_in;
    sda_prev_next = sda_in;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_prev_next;
      sda_prev_reg <= sda_prev_next;
    end
  end

  // At 40 MHz even a 1 MHz bus clock gives many samples per phase
  assign ev.scl_level = scl_in; // see [RULE_06]
  assign ev.sda_level = sda_in;
  assign ev.scl_rise = scl_in & ~scl_prev_reg;
  assign ev.scl_fall = ~scl_in & scl_prev_reg;
  assign ev.start = scl_in & scl_prev_reg & sda_prev_reg & ~sda_in;
  assign ev.stop = scl_in & scl_prev_reg & ~sda_prev_reg & sda_in;
endmodule

// ---- core/excitation_current_routing_config.sv ----
// Excitation current routing register bank behind a serial bus target port
// Summary of operation
// [RULE_01] Route code of the first source in bits 7:5: 0 off, 1-4 analog inputs, 5/6 refs, 7 reserved.
// [RULE_02] Route code of the second source in bits 4:2 uses the same code assignment.
// [RULE_03] Both route fields are zero after reset, so no source is connected.
// [RULE_04] Bits 1:0 of the routing register read as zero; the controller writes zeros there.
// [RULE_05] The target never drives the clock line, so it never stretches the clock.
// [RULE_06] The target works with standard, fast and fast-plus controllers, master-only included.
// [RULE_07] Two four-level strap pins choose one of sixteen target addresses.
// [RULE_08] The conversion-ready output is open drain and only pulls low.
// [RULE_09] A shared three-bit magnitude field sets both sources, and code zero turns both off.
// [RULE_10] The controller does not write reserved code 7 into a route field.
// [RULE_11] Reading the routing register returns the last written routes with low bits zero.
`timescale 1ns/1ps
module excitation_current_routing_config #(
  // Upper address bits; value is arbitrary
  parameter logic [2:0] ADDR_BASE = 3'h4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Serial bus, clock is input only
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Address straps: 0 ground, 1 supply, 2 data line, 3 clock line
  input wire logic [1:0] addr_strap_lo,
  input wire logic [1:0] addr_strap_hi,
  // Conversion ready pin
  input wire logic result_pending,
  output logic conversion_ready_n_out,
  output logic conversion_ready_oe_n,
  // Excitation source control
  output logic [2:0] excitation_magnitude_sel,
  output logic [5:0] first_excitation_source,
  output logic [5:0] second_excitation_source
);
  line_events_if ev ();

  bus_line_sampler u_sampler (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .ev(ev)
  );

  routing_pkg::bus_state_e st_reg, st_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] ptr_reg, ptr_next;
  logic rw_reg, rw_next;
  logic nack_reg, nack_next;
  logic oe_n_reg, oe_n_next;
  logic [2:0] first_current_route_sel_reg, first_current_route_sel_next;
  logic [2:0] second_current_route_sel_reg, second_current_route_sel_next;
  logic [2:0] mag_reg, mag_next;
  logic [6:0] addr_reg, addr_next;
  logic strap_taken_reg, strap_taken_next;
  logic ready_oe_n_reg, ready_oe_n_next;
  logic [7:0] read_byte;
  logic [1:0][2:0] route_sel;
  logic [1:0][5:0] conn_reg, conn_next;

  // Readback of the addressed register
  always_comb begin
    if (ptr_reg == routing_pkg::REG_ROUTING_IDX) begin
      read_byte = {first_current_route_sel_reg, second_current_route_sel_reg,
                   routing_pkg::RSVD_READ}; // see [RULE_04] see [RULE_11]
    end else if (ptr_reg == routing_pkg::REG_MAGNITUDE_IDX) begin
      read_byte = {routing_pkg::MAG_REG_PAD, mag_reg};
    end else begin
      read_byte = 8'h00;
    end
  end

  // Bus target protocol and register writes
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    ptr_next = ptr_reg;
    rw_next = rw_reg;
    nack_next = nack_reg;
    oe_n_next = oe_n_reg;
    first_current_route_sel_next = first_current_route_sel_reg;
    second_current_route_sel_next = second_current_route_sel_reg;
    mag_next = mag_reg;
    if (ev.stop) begin
      st_next = routing_pkg::ST_IDLE;
      oe_n_next = 1'b1;
    end else if (ev.start) begin
      st_next = routing_pkg::ST_ADDR;
      cnt_next = 4'h0;
      oe_n_next = 1'b1;
    end else begin
      case (st_reg)
        routing_pkg::ST_IDLE: begin
          oe_n_next = 1'b1;
        end
        routing_pkg::ST_ADDR, routing_pkg::ST_PTR, routing_pkg::ST_WDATA: begin
          if (ev.scl_rise && cnt_reg != routing_pkg::BITS_PER_BYTE) begin
            shift_next = {shift_reg[6:0], ev.sda_level};
            cnt_next = cnt_reg + 4'h1;
          end else if (ev.scl_fall && cnt_reg == routing_pkg::BITS_PER_BYTE) begin
            cnt_next = 4'h0;
            oe_n_next = 1'b0;
            if (st_reg == routing_pkg::ST_ADDR) begin
              if (shift_reg[7:1] == addr_reg) begin // see [RULE_07]
                rw_next = shift_reg[0];
                st_next = routing_pkg::ST_ADDR_ACK;
              end else begin
                oe_n_next = 1'b1;
                st_next = routing_pkg::ST_IDLE;
              end
            end else if (st_reg == routing_pkg::ST_PTR) begin
              ptr_next = shift_reg;
              st_next = routing_pkg::ST_PTR_ACK;
            end else begin
              st_next = routing_pkg::ST_WDATA_ACK;
              if (ptr_reg == routing_pkg::REG_ROUTING_IDX) begin
                // Low two bits are dropped; they read back as zero
                first_current_route_sel_next =
                  shift_reg[routing_pkg::ROUTE1_HI:routing_pkg::ROUTE1_LO]; // see [RULE_01]
                second_current_route_sel_next =
                  shift_reg[routing_pkg::ROUTE2_HI:routing_pkg::ROUTE2_LO]; // see [RULE_02]
              end else if (ptr_reg == routing_pkg::REG_MAGNITUDE_IDX) begin
                mag_next = shift_reg[2:0]; // see [RULE_09]
              end
            end
          end
        end
        routing_pkg::ST_ADDR_ACK, routing_pkg::ST_PTR_ACK, routing_pkg::ST_WDATA_ACK: begin
          if (ev.scl_fall) begin
            if (st_reg == routing_pkg::ST_ADDR_ACK && rw_reg) begin
              shift_next = read_byte;
              oe_n_next = read_byte[7];
              cnt_next = 4'h0;
              st_next = routing_pkg::ST_RDATA;
            end else begin
              oe_n_next = 1'b1;
              st_next = (st_reg == routing_pkg::ST_ADDR_ACK) ? routing_pkg::ST_PTR
                                                             : routing_pkg::ST_WDATA;
            end
          end
        end
        routing_pkg::ST_RDATA: begin
          if (ev.scl_fall) begin
            if (cnt_reg == routing_pkg::LAST_READ_BIT) begin
              oe_n_next = 1'b1;
              st_next = routing_pkg::ST_RACK;
            end else begin
              shift_next = {shift_reg[6:0], 1'b0};
              oe_n_next = shift_reg[6];
              cnt_next = cnt_reg + 4'h1;
            end
          end
        end
        routing_pkg::ST_RACK: begin
          if (ev.scl_rise) begin
            nack_next = ev.sda_level;
          end else if (ev.scl_fall) begin
            if (nack_reg) begin
              st_next = routing_pkg::ST_IDLE;
            end else begin
              shift_next = read_byte;
              oe_n_next = read_byte[7];
              cnt_next = 4'h0;
              st_next = routing_pkg::ST_RDATA;
            end
          end
        end
        default: begin
          st_next = routing_pkg::ST_IDLE;
          oe_n_next = 1'b1;
        end
      endcase
    end
  end

  // Strap capture once after reset release; ready pin only ever pulls low
  always_comb begin
    strap_taken_next = 1'b1;
    addr_next = strap_taken_reg ? addr_reg
                                : {ADDR_BASE, addr_strap_hi, addr_strap_lo}; // see [RULE_07]
    ready_oe_n_next = ~result_pending; // see [RULE_08]
  end

  // Route decoding per source
  assign route_sel[0] = first_current_route_sel_reg;
  assign route_sel[1] = second_current_route_sel_reg;
  for (genvar i = 0; i < 2; i++) begin : g_src
    always_comb begin
      conn_next[i] = '0;
      // Reserved code leaves the source unconnected, see [RULE_10]
      if (mag_reg != routing_pkg::MAG_OFF && route_sel[i] != routing_pkg::ROUTE_OFF &&
          route_sel[i] != routing_pkg::ROUTE_RSVD) begin // see [RULE_01] see [RULE_02]
        conn_next[i][3'(route_sel[i] - routing_pkg::ROUTE_ANALOG_IN_0)] = 1'b1; // see [RULE_09]
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= routing_pkg::ST_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      oe_n_reg <= 1'b1;
      first_current_route_sel_reg <= routing_pkg::ROUTE_RESET; // see [RULE_03]
      second_current_route_sel_reg <= routing_pkg::ROUTE_RESET; // see [RULE_03]
      mag_reg <= routing_pkg::MAG_RESET;
      addr_reg <= 7'h00;
      strap_taken_reg <= 1'b0;
      ready_oe_n_reg <= 1'b1;
      conn_reg <= '0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      rw_reg <= rw_next;
      nack_reg <= nack_next;
      oe_n_reg <= oe_n_next;
      first_current_route_sel_reg <= first_current_route_sel_next;
      second_current_route_sel_reg <= second_current_route_sel_next;
      mag_reg <= mag_next;
      addr_reg <= addr_next;
      strap_taken_reg <= strap_taken_next;
      ready_oe_n_reg <= ready_oe_n_next;
      conn_reg <= conn_next;
    end
  end

  // Both pins only ever pull low
  assign sda_out = 1'b0; // see [RULE_08]
  assign conversion_ready_n_out = 1'b0; // see [RULE_08]
  assign sda_oe_n = oe_n_reg; // see [RULE_05]
  assign conversion_ready_oe_n = ready_oe_n_reg;
  assign excitation_magnitude_sel = mag_reg;
  assign first_excitation_source = conn_reg[0];
  assign second_excitation_source = conn_reg[1];

  // Checks
  logic boot_reg;
  logic [2:0] shift_route1;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      boot_reg <= 1'b0;
    end else begin
      boot_reg <= 1'b1;
    end
  end
  assign shift_route1 = shift_reg[7:5];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  property p_route1_ref_pos_in;
    (first_current_route_sel_reg == routing_pkg::ROUTE_REF_POS_IN && mag_reg != routing_pkg::MAG_OFF)
      |=> first_excitation_source == 6'h10;
  endproperty
  a_route1_ref_pos_in: assert property (p_route1_ref_pos_in) else $error("first source not on ref pos"); // see [RULE_01]
  property p_route2_rsvd;
    second_current_route_sel_reg == routing_pkg::ROUTE_RSVD |=> second_excitation_source == 6'h00;
  endproperty
  a_route2_rsvd: assert property (p_route2_rsvd) else $error("reserved route connected"); // see [RULE_02]
  property p_reset_zero;
    !boot_reg |-> (first_current_route_sel_reg == 3'h0 && second_current_route_sel_reg == 3'h0
                   && first_excitation_source == 6'h00 && second_excitation_source == 6'h00);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("routing not zero after reset"); // see [RULE_03]
  property p_rsvd_read;
    (st_reg == routing_pkg::ST_ADDR_ACK && rw_reg && ev.scl_fall && !ev.stop && !ev.start &&
     ptr_reg == routing_pkg::REG_ROUTING_IDX) |=> shift_reg[1:0] == 2'h0 && st_reg == routing_pkg::ST_RDATA;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bits read nonzero"); // see [RULE_04]
  property p_drive_window;
    !sda_oe_n |-> st_reg inside {routing_pkg::ST_ADDR_ACK, routing_pkg::ST_PTR_ACK,
                                 routing_pkg::ST_WDATA_ACK, routing_pkg::ST_RDATA};
  endproperty
  a_drive_window: assert property (p_drive_window) else $error("data line driven out of turn"); // see [RULE_05]
  property p_addr_miss;
    (st_reg == routing_pkg::ST_ADDR && ev.scl_fall && !ev.stop && !ev.start && cnt_reg == 4'h8 &&
     shift_reg[7:1] != addr_reg) |=> st_reg == routing_pkg::ST_IDLE ##1 sda_oe_n;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("foreign address answered"); // see [RULE_07]
  property p_ready_pin;
    result_pending |=> !conversion_ready_oe_n && conversion_ready_n_out == 1'b0;
  endproperty
  a_ready_pin: assert property (p_ready_pin) else $error("ready pin not pulled low"); // see [RULE_08]
  property p_mag_off;
    mag_reg == routing_pkg::MAG_OFF |=> first_excitation_source == 6'h00 && second_excitation_source == 6'h00;
  endproperty
  a_mag_off: assert property (p_mag_off) else $error("source on with magnitude off"); // see [RULE_09]
  property p_write_back;
    (st_reg == routing_pkg::ST_WDATA && ev.scl_fall && !ev.stop && !ev.start && cnt_reg == 4'h8 &&
     ptr_reg == routing_pkg::REG_ROUTING_IDX) |=> first_current_route_sel_reg == $past(shift_route1);
  endproperty
  a_write_back: assert property (p_write_back) else $error("route field not stored"); // see [RULE_11]
  c_write_route: cover property (st_reg == routing_pkg::ST_WDATA_ACK && ptr_reg == routing_pkg::REG_ROUTING_IDX);
  c_read_route: cover property (st_reg == routing_pkg::ST_RACK && ptr_reg == routing_pkg::REG_ROUTING_IDX);
  c_addr_ack: cover property (st_reg == routing_pkg::ST_ADDR_ACK);
  c_source_on: cover property (first_excitation_source != 6'h00);
endmodule

// ---- core/line_events_if.sv ----
// Sampled serial bus line levels and edge events
`timescale 1ns/1ps
interface line_events_if;
  logic scl_level;
  logic sda_level;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  modport src (output scl_level, sda_level, scl_rise, scl_fall, start, stop);
  modport dst (input scl_level, sda_level, scl_rise, scl_fall, start, stop);
endinterface

// ---- core/routing_pkg.sv ----
// Constants shared by the excitation routing register bank
package routing_pkg;
  // Register pointer values
  localparam logic [7:0] REG_MAGNITUDE_IDX = 8'h02;
  localparam logic [7:0] REG_ROUTING_IDX = 8'h03;
  // Field positions
  localparam int ROUTE1_HI = 7;
  localparam int ROUTE1_LO = 5;
  localparam int ROUTE2_HI = 4;
  localparam int ROUTE2_LO = 2;
  // Route codes
  localparam logic [2:0] ROUTE_OFF = 3'h0;
  localparam logic [2:0] ROUTE_ANALOG_IN_0 = 3'h1;
  localparam logic [2:0] ROUTE_REF_POS_IN = 3'h5;
  localparam logic [2:0] ROUTE_REF_NEG_IN = 3'h6;
  localparam logic [2:0] ROUTE_RSVD = 3'h7;
  // Connect vector: bits 0..3 analog inputs, 4 positive ref, 5 negative ref
  localparam int CONN_W = 6;
  localparam int CONN_REF_POS_IN = 4;
  localparam int CONN_REF_NEG_IN = 5;
  // Magnitude and reset values
  localparam logic [2:0] MAG_OFF = 3'h0;
  localparam logic [2:0] ROUTE_RESET = 3'h0;
  localparam logic [2:0] MAG_RESET = 3'h0;
  localparam logic [1:0] RSVD_READ = 2'h0;
  localparam logic [4:0] MAG_REG_PAD = 5'h00;
  // Bus framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_READ_BIT = 4'h7;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK
  } bus_state_e;
endpackage
